/* wwd_window_watchdog.sv */
// Window watchdog: downcounter, window compare, halt handling, registers.
//
// Operation
// [R1] Software writes always carry count top bit set.
// [R2] Count decrements once per 16384 clock cycles.
// [R3] Active watchdog resets when count leaves 0x40.
// [R4] Activation bit set by software, cleared by reset.
// [R5] Resets only while activated in software mode; the halt reset option resets even when inactive.
// [R6] Hardware option makes watchdog always active.
// [R7] Control low bits read back the live count.
// [R8] Window register holds seven-bit compare value.
// [R9] Slow and wait modes keep normal counting.
// [R10] Plain halt: no reset, one decrement, freeze.
// [R11] Interrupt leaving halt resumes counting after delay.
// [R12] Reset ending halt leaves watchdog disabled.
// [R13] Halt with halt reset option resets instead.
// [R14] Active halt freezes count, interrupt resumes immediately.
// [R15] Reset ending active halt resumes after delay.
// [R16] Software reloads count before executing halt.
// [R17] Reload above window value resets the device.
// [R18] Downcounter runs even while watchdog inactive.
// [R19] Writing activation set, top bit clear resets.
// [R20] Prescaler runs freely, not cleared by reload.
//
// Strobed register access and the register offsets are this design's own decisions.
module wwd_window_watchdog
  import wwd_pkg::*;
#(
  parameter int PRESCALE = WWD_PRESCALE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Option byte settings.
  input wire logic hw_watchdog_option_i,
  input wire logic halt_reset_option_i,
  input wire logic wake_delay_long_i,
  // Processor power management.
  input wire logic halt_exec_i,
  input wire logic rtc_irq_enable_i,
  input wire logic osc_irq_i,
  input wire logic ext_irq_i,
  // Results.
  output logic wdg_reset_o,
  output logic halted_o,
  output logic counting_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Timing helpers.

  wwd_timing_if tim ();

  wwd_prescaler #(
    .PRESCALE(PRESCALE)
  ) u_prescaler (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .tim(tim)
  );

  wwd_wake_delay u_wake_delay (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .tim(tim)
  );

  //////////////////////////////////////////////////////////////////////////////
  // State.

  logic activation_bit;
  logic [6:0] count;
  logic [6:0] window;
  logic reset_req;
  logic [7:0] rdata;
  wwd_state_type state;

  logic next_activation_bit;
  logic [6:0] next_count;
  logic [6:0] next_window;
  logic next_reset_req;
  logic [7:0] next_rdata;
  wwd_state_type next_state;

  //////////////////////////////////////////////////////////////////////////////
  // Decode.

  wire logic sel_control;
  wire logic sel_window;
  wire logic ctrl_wr;
  wire logic win_wr;
  wire logic watchdog_active;
  wire logic active_after_wr;
  wire logic wr_top_clear;
  wire logic wr_above_window;
  wire logic write_fault;
  wire logic run_state;
  wire logic counting;
  wire logic decrement;
  wire logic expire_fault;
  wire logic halt_plain;
  wire logic halt_active;
  wire logic halt_fault;
  wire logic [6:0] count_minus_one;
  wire logic [7:0] control_view;
  wire logic [7:0] window_view;

  assign sel_control = (addr_i == WWD_ADDR_CONTROL);
  assign sel_window = (addr_i == WWD_ADDR_WINDOW);
  assign ctrl_wr = wr_i && sel_control;
  assign win_wr = wr_i && sel_window;

  // With the hardware option the activation bit is simply ignored.
  assign watchdog_active = activation_bit || hw_watchdog_option_i; // [R5] [R6]

  // A write that sets the activation bit is judged as already active.
  assign active_after_wr = watchdog_active || wdata_i[WWD_ACT_BIT];
  // Software relies on the top bit being set in every control write.
  assign wr_top_clear = !wdata_i[WWD_TOP_BIT]; // [R1] [R19]
  assign wr_above_window = (count > window); // [R17]
  assign write_fault = ctrl_wr && active_after_wr &&
                       (wr_top_clear || wr_above_window); // [R17] [R19]

  // The count is frozen while halted, after the one halt-entry decrement, and during the wake-up delay.
  assign run_state = (state == WWD_ST_RUN) && !tim.delay_busy; // [R11] [R15]
  // Slow and wait modes are not inputs here: they never touch the rate.
  assign counting = run_state || (state == WWD_ST_HALT_DEC); // [R9] [R18]
  assign decrement = tim.tick && counting; // [R2] [R18]
  assign count_minus_one = count - 7'h01;

  // The single decrement on halt entry never raises a reset.
  assign expire_fault = tim.tick && run_state && watchdog_active &&
                        (count == WWD_COUNT_EXPIRE); // [R3] [R10]

  assign halt_active = halt_exec_i && (state == WWD_ST_RUN) &&
                       rtc_irq_enable_i; // [R14]
  assign halt_plain = halt_exec_i && (state == WWD_ST_RUN) &&
                      !rtc_irq_enable_i && !halt_reset_option_i; // [R10]
  assign halt_fault = halt_exec_i && (state == WWD_ST_RUN) &&
                      !rtc_irq_enable_i && halt_reset_option_i; // [R13]

  assign control_view = {activation_bit, count}; // [R7]
  assign window_view = {1'b0, window}; // [R8]

  assign tim.delay_long = wake_delay_long_i;
  assign tim.delay_start = (state == WWD_ST_HALT_DEC ||
                            state == WWD_ST_HALTED) && ext_irq_i; // [R11]

  //////////////////////////////////////////////////////////////////////////////
  // Register file.

  always_comb begin
    next_activation_bit = activation_bit;
    next_window = window;
    next_rdata = 8'h00;
    // Writing zero to the activation bit leaves it set.
    if (ctrl_wr && wdata_i[WWD_ACT_BIT]) begin
      next_activation_bit = 1'b1; // [R4]
    end
    if (win_wr) begin
      next_window = wdata_i[6:0]; // [R8]
    end
    if (rd_i && sel_control) begin
      next_rdata = control_view; // [R7]
    end else if (rd_i && sel_window) begin
      next_rdata = window_view;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Downcounter. A reload beats a decrement in the same cycle.

  always_comb begin
    next_count = count;
    if (ctrl_wr) begin
      next_count = wdata_i[6:0];
    end else if (decrement) begin
      next_count = count_minus_one; // [R2] [R18]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Halt sequencing.

  always_comb begin
    next_state = state;
    case (state)
      WWD_ST_RUN: begin
        if (halt_active) begin
          next_state = WWD_ST_ACTIVE_HALT; // [R14]
        end else if (halt_plain) begin
          next_state = WWD_ST_HALT_DEC; // [R10]
        end
      end
      WWD_ST_HALT_DEC: begin
        if (ext_irq_i) begin
          next_state = WWD_ST_WAKE; // [R11]
        end else if (tim.tick) begin
          next_state = WWD_ST_HALTED; // [R10]
        end
      end
      WWD_ST_HALTED: begin
        if (ext_irq_i) begin
          next_state = WWD_ST_WAKE; // [R11]
        end
      end
      WWD_ST_ACTIVE_HALT: begin
        if (osc_irq_i || ext_irq_i) begin
          next_state = WWD_ST_RUN; // [R14]
        end
      end
      WWD_ST_WAKE: begin
        next_state = WWD_ST_RUN;
      end
      default: begin
        next_state = WWD_ST_RUN;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Device reset request. It stays high until the system reset returns,
  // which also clears the activation bit after any halt.

  assign next_reset_req = reset_req || write_fault || expire_fault ||
                          halt_fault; // [R3] [R13] [R17] [R19]

  //////////////////////////////////////////////////////////////////////////////
  // Flip-flops. Each register has its own short process so that the reset
  // value of every field can be read at a glance.

  // Only a reset clears the activation bit; a reset that ends a halt
  // therefore always leaves the software watchdog disabled.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      activation_bit <= WWD_ACT_RESET; // [R4] [R12]
    end else begin
      activation_bit <= next_activation_bit;
    end
  end

  // The count restarts from its top value after every reset.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count <= WWD_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      window <= WWD_WINDOW_RESET;
    end else begin
      window <= next_window;
    end
  end

  // The request is a level; whoever drives the system reset must return
  // reset_i, otherwise the request never drops.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reset_req <= 1'b0;
    end else begin
      reset_req <= next_reset_req;
    end
  end

  // Read data stand for one cycle only and are zero otherwise.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= WWD_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs. The wake state is not reported as halted: the processor is
  // already running again while the wake-up delay holds the count.

  assign rdata_o = rdata;
  assign wdg_reset_o = reset_req;
  assign halted_o = (state == WWD_ST_HALT_DEC) ||
                    (state == WWD_ST_HALTED) ||
                    (state == WWD_ST_ACTIVE_HALT);
  assign counting_o = counting;

endmodule // wwd_window_watchdog

/* wwd_pkg.sv */
// Shared constants and types of the window watchdog.
package wwd_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, plain byte addresses on the register port.
  localparam logic [7:0] WWD_ADDR_CONTROL = 8'h2F;
  localparam logic [7:0] WWD_ADDR_WINDOW = 8'h30;

  // Field positions.
  localparam int WWD_ACT_BIT = 7;
  localparam int WWD_TOP_BIT = 6;

  // Values after reset.
  localparam logic WWD_ACT_RESET = 1'b0;
  localparam logic [6:0] WWD_COUNT_RESET = 7'h7F;
  localparam logic [6:0] WWD_WINDOW_RESET = 7'h7F;

  // The count value from which the next decrement clears the top bit.
  localparam logic [6:0] WWD_COUNT_EXPIRE = 7'h40;

  //////////////////////////////////////////////////////////////////////////////
  // Timing, in cycles of the 125 MHz reference clock.
  localparam int WWD_CLK_PERIOD_NS = 8;
  localparam int WWD_PRESCALE_CYC = 16384;
  localparam int WWD_WAKE_SHORT_CYC = 256;
  localparam int WWD_WAKE_LONG_CYC = 4096;
  localparam int WWD_WAKE_W = 13;

  //////////////////////////////////////////////////////////////////////////////
  // Power state of the watchdog as seen from the processor halt logic.
  typedef enum logic [2:0] {
    WWD_ST_RUN,
    WWD_ST_HALT_DEC,
    WWD_ST_HALTED,
    WWD_ST_ACTIVE_HALT,
    WWD_ST_WAKE
  } wwd_state_type;

endpackage : wwd_pkg

/* wwd_timing_if.sv */
// Timing signals between the watchdog core, its prescaler and wake delay.
interface wwd_timing_if;
  logic tick;
  logic delay_start;
  logic delay_long;
  logic delay_busy;

  modport prescaler (output tick);
  modport delay (input delay_start, input delay_long, output delay_busy);
  modport core (input tick, output delay_start, output delay_long,
                input delay_busy);
endinterface : wwd_timing_if

/* wwd_prescaler.sv */
// Free-running decrement prescaler of the window watchdog.
module wwd_prescaler
  import wwd_pkg::*;
#(
  parameter int PRESCALE = WWD_PRESCALE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  wwd_timing_if.prescaler tim
);

  localparam int PW = $clog2(PRESCALE);
  localparam logic [PW-1:0] LAST = PW'(PRESCALE - 1);

  logic [PW-1:0] phase;
  logic [PW-1:0] next_phase;

  // A reload does not touch the phase, so the first decrement after a
  // write lands anywhere within one prescaler period.
  assign next_phase = (phase == LAST) ? '0 : phase + PW'(1); // [R20]
  assign tim.tick = (phase == LAST); // [R2]

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end

endmodule // wwd_prescaler

/* wwd_wake_delay.sv */
// Delay counter that holds the watchdog frozen after a wake-up.
module wwd_wake_delay
  import wwd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  wwd_timing_if.delay tim
);

  localparam logic [WWD_WAKE_W-1:0] SHORT_LOAD =
    WWD_WAKE_W'(WWD_WAKE_SHORT_CYC);
  localparam logic [WWD_WAKE_W-1:0] LONG_LOAD =
    WWD_WAKE_W'(WWD_WAKE_LONG_CYC);

  logic [WWD_WAKE_W-1:0] remain;
  logic [WWD_WAKE_W-1:0] next_remain;
  wire logic [WWD_WAKE_W-1:0] load_value;

  assign load_value = tim.delay_long ? LONG_LOAD : SHORT_LOAD;
  assign tim.delay_busy = (remain != '0);

  always_comb begin
    next_remain = remain;
    if (tim.delay_start) begin
      next_remain = load_value;
    end else if (remain != '0) begin
      next_remain = remain - WWD_WAKE_W'(1);
    end
  end

  // Busy right from reset, so the count waits one delay after every reset.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      remain <= SHORT_LOAD;
    end else begin
      remain <= next_remain;
    end
  end

endmodule // wwd_wake_delay

/* wwd_assertions.sv */
// Port assertions of the window watchdog.
module wwd_assertions
  import wwd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic halt_reset_option_i,
  input wire logic halt_exec_i,
  input wire logic rtc_irq_enable_i,
  input wire logic wdg_reset_o,
  input wire logic halted_o,
  input wire logic counting_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  // Halt is only taken while running, which these two flags reveal outside the wake-up delay.
  wire logic run = halt_exec_i && counting_o && !halted_o;
  wire logic ctl_wr = wr_i && addr_i == WWD_ADDR_CONTROL;
  wire logic win_rd = rd_i && addr_i == WWD_ADDR_WINDOW;
  chk_reset_sticky: assert property (wdg_reset_o |=> wdg_reset_o)
    else $error("reset request dropped");
  chk_forced_reset: assert property (
    ctl_wr && wdata_i[7:6] == 2'b10 |=> wdg_reset_o)
    else $error("forced reset missing");
  chk_halt_reset: assert property (
    run && !rtc_irq_enable_i && halt_reset_option_i |=> wdg_reset_o)
    else $error("halt option reset missing");
  chk_active_halt: assert property (
    run && rtc_irq_enable_i |=> halted_o && !counting_o)
    else $error("active halt not entered");
  chk_plain_halt: assert property (
    run && !rtc_irq_enable_i && !halt_reset_option_i
    |=> halted_o && !$rose(wdg_reset_o))
    else $error("plain halt wrong");
  chk_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  chk_window_msb: assert property (win_rd |=> !rdata_o[7])
    else $error("window bit 7 set");
  chk_boot_frozen: assert property (
    $fell(reset_i) |-> !counting_o [*8])
    else $error("count runs right after reset");
  cover property (ctl_wr ##1 $rose(wdg_reset_o));
  cover property (run ##1 halted_o);
  cover property (halted_o ##1 !halted_o);
endmodule // wwd_assertions

/* wwd_window_watchdog_bench.sv */
// Self-checking bench of the window watchdog block.
module wwd_window_watchdog_bench
  import wwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // A short prescaler keeps the run brief; expectations derive from it.
  localparam int PS = 16;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v, w;
  logic hw_watchdog_option_i = 1'b0, halt_reset_option_i = 1'b0;
  logic wake_delay_long_i = 1'b0, halt_exec_i = 1'b0;
  logic rtc_irq_enable_i = 1'b0, osc_irq_i = 1'b0, ext_irq_i = 1'b0;
  logic wdg_reset_o, halted_o, counting_o;
  int err_count = 0, checks = 0, n;
  wwd_window_watchdog #(.PRESCALE(PS)) DUT (.ref_clk_i, .reset_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .hw_watchdog_option_i,
    .halt_reset_option_i, .wake_delay_long_i, .halt_exec_i,
    .rtc_irq_enable_i, .osc_irq_i, .ext_irq_i, .wdg_reset_o, .halted_o,
    .counting_o);
  always #4 ref_clk_i = ~ref_clk_i;
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // Each strobe is followed by an idle cycle so no signal is set twice.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    cyc(1);
    wr_i <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    cyc(1);
    rd_i <= 1'b0;
    d = rdata_o;
    cyc(1);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1) begin
      if (n++ == lim) begin
        err_count++;
        $display("Error at %0t: wait timed out", $time);
        end_sim();
      end
      cyc(1);
    end
  endtask
  task automatic rst(input logic h);
    reset_i <= 1'b1;
    hw_watchdog_option_i <= h;
    cyc(8);
    reset_i <= 1'b0;
  endtask
  task automatic hlt(input logic r, input logic o);
    rtc_irq_enable_i <= r;
    halt_reset_option_i <= o;
    halt_exec_i <= 1'b1;
    cyc(1);
    halt_exec_i <= 1'b0;
    cyc(1);
  endtask
  function automatic logic exp_rst(input logic h, input logic [7:0] d);
    return (h | d[7]) & ~d[6];
  endfunction
  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9A0DF0F9));
    rst(1'b0);
    rd(WWD_ADDR_CONTROL, v);
    cmp(v, 8'h7F);
    rd(WWD_ADDR_WINDOW, v);
    cmp(v, 8'h7F);
    rd(8'h31, v);
    cmp(v, 8'h00);
    repeat (6) begin
      w = 8'($urandom);
      wr(WWD_ADDR_WINDOW, w);
      rd(WWD_ADDR_WINDOW, v);
      cmp(v, {1'b0, w[6:0]});
      wr(WWD_ADDR_CONTROL, {1'b0, w[6:0]});
      rd(WWD_ADDR_CONTROL, v);
      cmp(v, {1'b0, w[6:0]});
      cmp({7'h00, wdg_reset_o}, 8'h00);
    end
    $display("Test registers done");
    wr(WWD_ADDR_WINDOW, 8'h7F);
    wr(WWD_ADDR_CONTROL, 8'h7F);
    cyc(300);
    rd(WWD_ADDR_CONTROL, v);
    cyc(8 * PS - 2);
    rd(WWD_ADDR_CONTROL, w);
    cmp(w, v - 8'h08);
    $display("Test counting done");
    wr(WWD_ADDR_CONTROL, 8'hC1);
    wr(WWD_ADDR_CONTROL, 8'h41);
    rd(WWD_ADDR_CONTROL, v);
    cmp(v & 8'hC0, 8'hC0);
    cmp({7'h00, wdg_reset_o}, 8'h00);
    wait_hi(wdg_reset_o, 2 * PS + 4);
    rd(WWD_ADDR_CONTROL, v);
    cmp(v, 8'hBF);
    $display("Test expiry done");
    rst(1'b0);
    cyc(300);
    wr(WWD_ADDR_CONTROL, 8'hFF);
    cmp({7'h00, wdg_reset_o}, 8'h00);
    wr(WWD_ADDR_WINDOW, 8'h50);
    wr(WWD_ADDR_CONTROL, 8'hFF);
    cmp({7'h00, wdg_reset_o}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rst(i[1]);
      w = {i[0], i[2], 6'($urandom)};
      wr(WWD_ADDR_CONTROL, w);
      cmp({7'h00, wdg_reset_o}, {7'h00, exp_rst(i[1], w)});
    end
    $display("Test write faults done");
    rst(1'b0);
    cyc(240);
    cmp({7'h00, counting_o}, 8'h00);
    wait_hi(counting_o, 40);
    hlt(1'b0, 1'b1);
    cmp({7'h00, wdg_reset_o}, 8'h01);
    rst(1'b0);
    cyc(300);
    hlt(1'b1, 1'b1);
    rd(WWD_ADDR_CONTROL, v);
    cyc(4 * PS);
    rd(WWD_ADDR_CONTROL, w);
    cmp(w, v);
    cmp({6'h00, halted_o, wdg_reset_o}, 8'h02);
    osc_irq_i <= 1'b1;
    cyc(1);
    osc_irq_i <= 1'b0;
    cyc(1);
    cmp({6'h00, halted_o, counting_o}, 8'h01);
    for (int l = 0; l < 2; l++) begin
      wake_delay_long_i <= l[0];
      // Reload just before halting, as software is asked to do.
      wr(WWD_ADDR_CONTROL, 8'h7F);
      rd(WWD_ADDR_CONTROL, v);
      hlt(1'b0, 1'b0);
      cyc(2 * PS);
      rd(WWD_ADDR_CONTROL, w);
      // A prescaler tick may land between the read and the halt.
      cmp({7'h00, (8'(v - w) inside {8'h01, 8'h02})}, 8'h01);
      cyc(4 * PS);
      rd(WWD_ADDR_CONTROL, v);
      cmp(v, w);
      ext_irq_i <= 1'b1;
      cyc(1);
      ext_irq_i <= 1'b0;
      n = l ? WWD_WAKE_LONG_CYC : WWD_WAKE_SHORT_CYC;
      cyc(n - 8);
      cmp({7'h00, counting_o}, 8'h00);
      wait_hi(counting_o, 16);
    end
    $display("Test halt done");
    end_sim();
  end
endmodule // wwd_window_watchdog_bench
bind wwd_window_watchdog wwd_assertions chk (.ref_clk_i, .reset_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .halt_reset_option_i,
  .halt_exec_i, .rtc_irq_enable_i, .wdg_reset_o, .halted_o, .counting_o);
